//--- inc/jtf_pkg.sv
// Function
// - Lanes carry either 8B/10B or 64B/66B coding, picked by a configuration input.
// - 8B/10B output keeps the older revision's character and handshake format.
// - At most eight lanes; four in the single-channel build; more lanes lower lane rate.
// - 64B/66B block sync comes from per-block sync headers, not the handshake pin.
// - 64B/66B ignores the handshake pin, except as an oscillator phase-sync strobe.
// - A captured SYSREF edge resets the multiframe or extended multiblock counters.
// - One device clock runs sampling reference, digital logic and serializer feed.
// - Forward error correction is available on the 64B/66B link layer.
// - No 64B/80B layer, no command channel, no CRC3 protection.
// - Subclass 1 transmitter only; usable by a subclass 0 receiver.
// - All lanes of one link are aligned; no multipoint reference alignment.
// - Handshake timing of either older revision is accepted in 8B/10B mode.
// - Samples pack into 8-bit octets, F octets per frame, frames spread over L lanes.
// - N significant bits travel in N' link bits; M converters, S samples per frame.
// - One mode field fixes all transport parameters.
// - Frames group into multiframes, or blocks, multiblocks and extended multiblocks.
// - Handshake low makes every lane in the mode's lane mask send a continuous comma stream; unused lanes send zero.
// - After handshake high, wait for the next multiframe edge, then send four ILAS multiframes.
// - Scrambling always on in 64B/66B; in 8B/10B only when scramble enable is set.
package jtf_pkg;
  localparam int          MAX_LANES     = 8;
  localparam int          LINK_BITS     = 16;
  localparam int          SAMPLE_BITS   = 12;
  localparam logic [7:0]  CHAR_COMMA    = 8'hBC;
  localparam logic [7:0]  CHAR_MF_START = 8'h1C;
  localparam logic [7:0]  CHAR_MF_END   = 8'h7C;
  localparam logic [7:0]  CHAR_CONFIG   = 8'h9C;
  localparam logic [2:0]  ILAS_LAST_MF  = 3'h3;
  localparam logic [4:0]  BLOCK_LAST    = 5'h07;
  localparam logic [4:0]  MB_LAST_BLOCK = 5'h1F;
  localparam logic [1:0]  HDR_DATA      = 2'h1;

  typedef enum logic [3:0] {
    ST_CGS  = 4'h1,
    ST_WAIT = 4'h2,
    ST_ILAS = 4'h4,
    ST_DATA = 4'h8
  } jtf_state_t;

  localparam jtf_state_t  RST_STATE     = ST_CGS;

  // Last octet index of a frame for each transport mode.
  function automatic logic [4:0] jtf_frame_last(input logic [3:0] m);
    case (m)
      4'h1:    return 5'h03;
      4'h2:    return 5'h07;
      4'h3:    return 5'h0F;
      default: return 5'h01;
    endcase
  endfunction : jtf_frame_last

  // Lanes used by each transport mode.
  function automatic logic [7:0] jtf_lane_mask(input logic [3:0] m);
    case (m)
      4'h1:    return 8'h0F;
      4'h2:    return 8'h03;
      4'h3:    return 8'h01;
      default: return 8'hFF;
    endcase
  endfunction : jtf_lane_mask

  // Self-synchronous scrambler, one octet MSB first; returns {state, octet}.
  function automatic logic [65:0] jtf_scramble(input logic [57:0] st, input logic [7:0] d,
                                               input logic wide);
    logic [57:0] s;
    logic [7:0]  q;
    logic        b;
    s = st;
    q = '0;
    for (int i = 7; i >= 0; i--) begin
      b    = d[i] ^ (wide ? (s[38] ^ s[57]) : (s[13] ^ s[14]));
      q[i] = b;
      s    = {s[56:0], b};
    end
    return {s, q};
  endfunction : jtf_scramble
endpackage : jtf_pkg

//--- hw/jtf_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module jtf_pin_sync #(
  parameter int W = 2
) (
  // Clock and reset.
  input  wire logic         mclk,
  input  wire logic         reset_n,
  // Pins and settled levels.
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] level
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] level_r;

  // A pin change counts only once the second and third stages agree.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r    <= '0;
      s2_r    <= '0;
      s3_r    <= '0;
      level_r <= '0;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          level_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign level = level_r;
endmodule : jtf_pin_sync
`default_nettype wire

//--- hw/jtf_transmit_framing.sv
`timescale 1ns/1ns
`default_nettype none
module jtf_transmit_framing #(
  parameter int MAX_LANES = jtf_pkg::MAX_LANES
) (
  // Device clock and reset.
  input  wire logic                           mclk,
  input  wire logic                           reset_n,
  // Configuration.
  input  wire logic                           encMode64,
  input  wire logic [3:0]                     transportModeSelect,
  input  wire logic                           scrambleEnable,
  input  wire logic                           fecEnable,
  input  wire logic                           handshakeForPhaseSync,
  input  wire logic [7:0]                     framesPerMfM1,
  input  wire logic [3:0]                     mbPerEmbM1,
  // Pins from the far side.
  input  wire logic                           sysrefPin,
  input  wire logic                           singleEndedHandshakePin_n,
  // Sample input.
  input  wire logic [MAX_LANES-1:0][15:0]     laneSample,
  output logic                                sampleTake,
  // Lane output.
  output logic      [MAX_LANES-1:0][7:0]      laneOctet,
  output logic      [MAX_LANES-1:0]           laneCtrl,
  output logic      [MAX_LANES-1:0]           laneActive,
  output logic      [1:0]                     syncHeader,
  output logic                                blockStart,
  output logic                                mfEdge,
  output logic                                fecActive,
  output logic                                phaseSyncPulse,
  output jtf_pkg::jtf_state_t                 linkState
);
  if (MAX_LANES != 4 && MAX_LANES != 8) begin : g_chk
    $error("MAX_LANES must be 4 or 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edges.

  logic [1:0] pinLvl;
  logic       sysrefPrev_r;
  logic       hsPrev_r;

  jtf_pin_sync #(.W(2)) u_sync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .pinIn   ({singleEndedHandshakePin_n, sysrefPin}),
    .level   (pinLvl)
  );

  wire sysrefRise = pinLvl[0] & ~sysrefPrev_r;
  wire hsHigh     = pinLvl[1];
  wire hsFall     = ~pinLvl[1] & hsPrev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Shared counters for all lanes.

  logic [4:0]          octIdx_r;
  logic [7:0]          frmIdx_r;
  logic [4:0]          blkIdx_r;
  logic [3:0]          embIdx_r;
  logic [2:0]          ilasMf_r;
  jtf_pkg::jtf_state_t st_r;
  jtf_pkg::jtf_state_t st_nxt;

  wire [4:0] frameLast = jtf_pkg::jtf_frame_last(transportModeSelect);
  wire [7:0] modeMask  = jtf_pkg::jtf_lane_mask(transportModeSelect);
  wire [MAX_LANES-1:0] laneMask = modeMask[MAX_LANES-1:0];
  wire [4:0] octLast   = encMode64 ? jtf_pkg::BLOCK_LAST : frameLast;
  wire       lastOct   = octIdx_r == octLast;
  wire       lastFrm   = frmIdx_r == framesPerMfM1;
  wire       lastBlk   = blkIdx_r == jtf_pkg::MB_LAST_BLOCK;
  wire       lastEmb   = embIdx_r == mbPerEmbM1;
  // End of a multiframe, or of an extended multiblock.
  wire       mfEnd     = lastOct & (encMode64 ? (lastBlk & lastEmb) : lastFrm);
  wire       mfFirst   = octIdx_r == 5'h00 && frmIdx_r == 8'h00;

  // Subclass 1: the counters take their phase from SYSREF only.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      octIdx_r <= '0;
      frmIdx_r <= '0;
      blkIdx_r <= '0;
      embIdx_r <= '0;
    end else if (sysrefRise) begin
      octIdx_r <= '0;
      frmIdx_r <= '0;
      blkIdx_r <= '0;
      embIdx_r <= '0;
    end else begin
      octIdx_r <= lastOct ? 5'h00 : octIdx_r + 5'h01;
      if (lastOct && !encMode64) begin
        frmIdx_r <= lastFrm ? 8'h00 : frmIdx_r + 8'h01;
      end
      if (lastOct && encMode64) begin
        blkIdx_r <= lastBlk ? 5'h00 : blkIdx_r + 5'h01;
        if (lastBlk) begin
          embIdx_r <= lastEmb ? 4'h0 : embIdx_r + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link start-up state machine.

  always_comb begin
    st_nxt = st_r;
    if (encMode64) begin
      st_nxt = jtf_pkg::ST_DATA;
    end else if (!hsHigh) begin
      st_nxt = jtf_pkg::ST_CGS;
    end else begin
      unique case (st_r)
        jtf_pkg::ST_CGS:  st_nxt = jtf_pkg::ST_WAIT;
        jtf_pkg::ST_WAIT: st_nxt = mfEnd ? jtf_pkg::ST_ILAS : jtf_pkg::ST_WAIT;
        jtf_pkg::ST_ILAS: begin
          if (mfEnd && ilasMf_r == jtf_pkg::ILAS_LAST_MF) begin
            st_nxt = jtf_pkg::ST_DATA;
          end
        end
        jtf_pkg::ST_DATA: st_nxt = jtf_pkg::ST_DATA;
        default:          st_nxt = jtf_pkg::ST_CGS;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r         <= jtf_pkg::RST_STATE;
      ilasMf_r     <= '0;
      sysrefPrev_r <= 1'b0;
      hsPrev_r     <= 1'b0;
    end else begin
      st_r         <= st_nxt;
      sysrefPrev_r <= pinLvl[0];
      hsPrev_r     <= pinLvl[1];
      if (st_r != jtf_pkg::ST_ILAS) begin
        ilasMf_r <= '0;
      end else if (mfEnd) begin
        ilasMf_r <= ilasMf_r + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-lane octet generation.

  localparam logic [15:0] SAMPLE_MASK = 16'hFFFF << (jtf_pkg::LINK_BITS - jtf_pkg::SAMPLE_BITS);

  wire inData   = st_r == jtf_pkg::ST_DATA;
  wire scrOn    = encMode64 | scrambleEnable;
  wire evenOct  = ~octIdx_r[0];
  wire ilasCfg  = ilasMf_r == 3'h1 && frmIdx_r == 8'h00 && octIdx_r == 5'h01;

  // A sample is taken at every even octet of a frame, so odd F is not served.
  assign sampleTake = inData & evenOct;

  logic [MAX_LANES-1:0][15:0] hold_r;
  logic [MAX_LANES-1:0][57:0] scr_r;
  logic [MAX_LANES-1:0][7:0]  oct_r;
  logic [MAX_LANES-1:0]       ctrl_r;

  for (genvar ln = 0; ln < MAX_LANES; ln++) begin : g_lane
    // Tail bits below the N significant bits are sent as zero.
    wire [15:0] masked  = laneSample[ln] & SAMPLE_MASK;
    wire [7:0]  rawData = evenOct ? masked[15:8] : hold_r[ln][7:0];
    wire [65:0] scrOut  = jtf_pkg::jtf_scramble(scr_r[ln], rawData, encMode64);
    wire [7:0]  dataOct = scrOn ? scrOut[7:0] : rawData;
    wire [7:0]  ilasOct = mfFirst ? jtf_pkg::CHAR_MF_START :
                          mfEnd   ? jtf_pkg::CHAR_MF_END   :
                          ilasCfg ? jtf_pkg::CHAR_CONFIG   : frmIdx_r;
    wire        ilasK   = mfFirst | mfEnd | ilasCfg;
    wire        inIlas  = st_r == jtf_pkg::ST_ILAS;
    wire [7:0]  octSel  = inData ? dataOct : inIlas ? ilasOct : jtf_pkg::CHAR_COMMA;
    wire        kSel    = inData ? 1'b0 : (inIlas ? ilasK : 1'b1);

    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        hold_r[ln] <= '0;
        scr_r[ln]  <= '0;
        oct_r[ln]  <= '0;
        ctrl_r[ln] <= 1'b0;
      end else begin
        if (sampleTake) begin
          hold_r[ln] <= masked;
        end
        // ILAS and comma octets never pass through the scrambler.
        if (inData && scrOn) begin
          scr_r[ln] <= scrOut[65:8];
        end
        oct_r[ln]  <= laneMask[ln] ? octSel : 8'h00;
        ctrl_r[ln] <= laneMask[ln] & kSel & ~encMode64;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Block framing and side outputs.

  logic [1:0] hdr_r;
  logic       blkStart_r;
  logic       mfEdge_r;
  logic       fec_r;
  logic       phase_r;

  // Only data headers are produced: no command channel and no CRC3 bits.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hdr_r      <= '0;
      blkStart_r <= 1'b0;
      mfEdge_r   <= 1'b0;
      fec_r      <= 1'b0;
      phase_r    <= 1'b0;
    end else begin
      hdr_r      <= encMode64 ? jtf_pkg::HDR_DATA : 2'h0;
      blkStart_r <= encMode64 & octIdx_r == 5'h00;
      mfEdge_r   <= mfEnd;
      fec_r      <= encMode64 & fecEnable;
      phase_r    <= encMode64 & handshakeForPhaseSync & hsFall;
    end
  end

  assign laneOctet      = oct_r;
  assign laneCtrl       = ctrl_r;
  assign laneActive     = laneMask;
  assign syncHeader     = hdr_r;
  assign blockStart     = blkStart_r;
  assign mfEdge         = mfEdge_r;
  assign fecActive      = fec_r;
  assign phaseSyncPulse = phase_r;
  assign linkState      = st_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_waitEdge;
    st_r == jtf_pkg::ST_WAIT && mfEnd && hsHigh && !encMode64;
  endsequence

  sequence s_ilasStart;
    st_r == jtf_pkg::ST_ILAS && mfFirst;
  endsequence

  property p_sysrefPhase;
    sysrefRise |=> octIdx_r == 5'h00 && frmIdx_r == 8'h00 && blkIdx_r == 5'h00;
  endproperty
  a_sysrefPhase: assert property (p_sysrefPhase) else $error("counters not reset by sysref");

  property p_comma;
    st_r == jtf_pkg::ST_CGS && !encMode64 && laneMask[0]
      |=> laneOctet[0] == jtf_pkg::CHAR_COMMA && laneCtrl[0];
  endproperty
  a_comma: assert property (p_comma) else $error("no comma during code sync");

  property p_ilasEntry;
    s_waitEdge ##1 !sysrefRise |-> st_r == jtf_pkg::ST_ILAS && ilasMf_r == 3'h0 && mfFirst;
  endproperty
  a_ilasEntry: assert property (p_ilasEntry) else $error("alignment not at multiframe edge");

  property p_ilasStartChar;
    s_ilasStart and laneMask[0] |=> laneOctet[0] == jtf_pkg::CHAR_MF_START && laneCtrl[0];
  endproperty
  a_ilasStartChar: assert property (p_ilasStartChar) else $error("multiframe start missing");

  property p_ilasLen;
    st_r == jtf_pkg::ST_ILAS |-> ilasMf_r <= jtf_pkg::ILAS_LAST_MF;
  endproperty
  a_ilasLen: assert property (p_ilasLen) else $error("alignment sequence too long");

  property p_ignoreHs64;
    encMode64 ##1 encMode64 |-> st_r == jtf_pkg::ST_DATA && laneCtrl == '0;
  endproperty
  a_ignoreHs64: assert property (p_ignoreHs64) else $error("handshake acted in 64b mode");

  property p_idleLane;
    !laneMask[MAX_LANES-1] |=> laneOctet[MAX_LANES-1] == 8'h00 && !laneCtrl[MAX_LANES-1];
  endproperty
  a_idleLane: assert property (p_idleLane) else $error("unused lane driven");

  property p_laneAlign;
    ##1 $stable(laneMask) |-> (laneCtrl == '0) || (laneCtrl == laneMask);
  endproperty
  a_laneAlign: assert property (p_laneAlign) else $error("lanes out of phase");

  property p_octetRange;
    octIdx_r <= octLast || $past(sysrefRise) || !$stable(transportModeSelect);
  endproperty
  a_octetRange: assert property (p_octetRange) else $error("octet index past frame");

  property p_tailZero;
    sampleTake |=> (hold_r[0] & ~SAMPLE_MASK) == 16'h0000;
  endproperty
  a_tailZero: assert property (p_tailZero) else $error("tail bits not zero");

  property p_header;
    encMode64 && octIdx_r == 5'h00 |=> blockStart && syncHeader == jtf_pkg::HDR_DATA;
  endproperty
  a_header: assert property (p_header) else $error("sync header missing");
endmodule : jtf_transmit_framing
`default_nettype wire

//--- tb/jtf_rx_model.sv
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module jtf_rx_model (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Control from the bench.
  input  wire logic       mode64,
  input  wire logic       reqSync,
  // Lane zero from the transmitter.
  input  wire logic [7:0] octet0,
  input  wire logic       ctrl0,
  input  wire logic       mfEdge,
  // Handshake back to the transmitter.
  output logic            handshakePin_n
);
  logic [2:0] commaCnt_r;

  // The receiver locks after four commas in a row and lets go on a multiframe edge.
  // It acts on the rising edge so that the bench's falling-edge requests never race it.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      commaCnt_r     <= 3'h0;
      handshakePin_n <= 1'b0;
    end else if (reqSync) begin
      commaCnt_r     <= 3'h0;
      handshakePin_n <= 1'b0;
    end else if (mode64) begin
      handshakePin_n <= 1'b1;
    end else if (!handshakePin_n) begin
      if (ctrl0 && octet0 == jtf_pkg::CHAR_COMMA) begin
        commaCnt_r <= (commaCnt_r == 3'h4) ? 3'h4 : commaCnt_r + 3'h1;
      end else begin
        commaCnt_r <= 3'h0;
      end
      if (commaCnt_r == 3'h4 && mfEdge) begin
        handshakePin_n <= 1'b1;
      end
    end
  end
endmodule : jtf_rx_model
`default_nettype wire

//--- tb/tb_jesd204c_transmit_framing.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; $display("[ERR] %0t got %h want %h", $time, g, e); end end
`define WAITC(c) begin for (int k = 0; k < 300 && (c) !== 1'b1; k++) @(negedge mclk); `CHK((c), 1'b1) end
////////////////////////////////////////////////////////////////////////////////
module tb_jesd204c_transmit_framing;
  typedef struct packed { logic [3:0] mode; logic [7:0] mask; } jtf_row_t;
  logic                mclk, reset_n, encMode64, scrambleEnable, fecEnable, handshakeForPhaseSync;
  logic                sysrefPin, hsPin_n, reqSync, sampleTake, blockStart, mfEdge, fecActive, phaseSyncPulse;
  logic [3:0]          transportModeSelect, mbPerEmbM1;
  logic [7:0]          framesPerMfM1, laneCtrl, laneActive;
  logic [7:0][15:0]    laneSample;
  logic [7:0][7:0]     laneOctet;
  logic [1:0]          syncHeader;
  jtf_pkg::jtf_state_t linkState;
  int                  errors, samples_checked, n, d1, d2;
  jtf_row_t            rows [5] = '{'{4'h0, 8'hFF}, '{4'h1, 8'h0F}, '{4'h2, 8'h03}, '{4'h3, 8'h01}, '{4'h9, 8'hFF}};

  always #5 mclk = ~mclk;

  jtf_transmit_framing u_dut (.mclk(mclk), .reset_n(reset_n), .encMode64(encMode64),
    .transportModeSelect(transportModeSelect), .scrambleEnable(scrambleEnable), .fecEnable(fecEnable),
    .handshakeForPhaseSync(handshakeForPhaseSync), .framesPerMfM1(framesPerMfM1), .mbPerEmbM1(mbPerEmbM1),
    .sysrefPin(sysrefPin), .singleEndedHandshakePin_n(hsPin_n), .laneSample(laneSample),
    .sampleTake(sampleTake), .laneOctet(laneOctet), .laneCtrl(laneCtrl), .laneActive(laneActive),
    .syncHeader(syncHeader), .blockStart(blockStart), .mfEdge(mfEdge), .fecActive(fecActive),
    .phaseSyncPulse(phaseSyncPulse), .linkState(linkState));

  jtf_rx_model u_rx (.mclk(mclk), .reset_n(reset_n), .mode64(encMode64), .reqSync(reqSync),
    .octet0(laneOctet[0]), .ctrl0(laneCtrl[0]), .mfEdge(mfEdge), .handshakePin_n(hsPin_n));

  //////////////////////////////////////////////////////////////////////////////
  task automatic doReset();
    reset_n = 1'b0;
    repeat (16) @(negedge mclk);
    reset_n = 1'b1;
  endtask : doReset

  // Counts the cycles from one pulse of a marker to the next.
  task automatic pulseGap(input logic blk, output int g);
    g = 0;
    `WAITC((blk ? blockStart : mfEdge))
    do begin
      @(negedge mclk);
      g++;
    end while ((blk ? blockStart : mfEdge) !== 1'b1 && g < 100);
  endtask : pulseGap

  // Distance from a timing pulse to the next multiframe edge, once the old phase has gone.
  task automatic sysrefDist(output int d);
    sysrefPin = 1'b1;
    repeat (2) @(negedge mclk);
    sysrefPin = 1'b0;
    repeat (6) @(negedge mclk);
    d = 8;
    while (mfEdge !== 1'b1 && d < 60) begin
      @(negedge mclk);
      d++;
    end
  endtask : sysrefDist

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end

  initial begin
    {mclk, reset_n, encMode64, scrambleEnable, fecEnable, handshakeForPhaseSync, sysrefPin, reqSync} = '0;
    transportModeSelect = 4'h0;
    mbPerEmbM1          = 4'h1;
    framesPerMfM1       = 8'h03;
    for (int i = 0; i < 8; i++) laneSample[i] = {8'hC3, 4'(i), 4'hF};
    foreach (rows[i]) begin
      @(negedge mclk);
      transportModeSelect = rows[i].mode;
      @(negedge mclk);
      `CHK(laneActive, rows[i].mask)
    end
    transportModeSelect = 4'h0;
    doReset();
    $display("test lane masks done");
    repeat (2) @(negedge mclk);
    `CHK(linkState, jtf_pkg::ST_CGS)
    `CHK(laneOctet, {8{jtf_pkg::CHAR_COMMA}})
    `CHK(laneCtrl, 8'hFF)
    `WAITC(laneCtrl[0] === 1'b1 && laneOctet[0] === jtf_pkg::CHAR_MF_START)
    `CHK(linkState, jtf_pkg::ST_ILAS)
    `CHK(laneOctet, {8{jtf_pkg::CHAR_MF_START}})
    n = 1;
    for (int k = 0; k < 400 && linkState !== jtf_pkg::ST_DATA; k++) begin
      @(negedge mclk);
      if (laneCtrl[0] === 1'b1 && laneOctet[0] === jtf_pkg::CHAR_MF_START) n++;
    end
    `CHK(n, 4)
    $display("test link start done");
    `WAITC(sampleTake)
    @(negedge mclk);
    for (int i = 0; i < 8; i++) `CHK(laneOctet[i], 8'hC3)
    @(negedge mclk);
    for (int i = 0; i < 8; i++) `CHK(laneOctet[i], 8'(i << 4))
    pulseGap(1'b0, n);
    `CHK(n, 8)
    sysrefDist(d1);
    repeat (3) @(negedge mclk);
    sysrefDist(d2);
    `CHK(d1, d2)
    `CHK(d1, 13)
    $display("test data and timing done");
    reqSync = 1'b1;
    @(negedge mclk);
    reqSync = 1'b0;
    `WAITC(linkState === jtf_pkg::ST_CGS)
    $display("test resync done");
    encMode64             = 1'b1;
    fecEnable             = 1'b1;
    handshakeForPhaseSync = 1'b1;
    doReset();
    repeat (8) @(negedge mclk);
    `CHK(linkState, jtf_pkg::ST_DATA)
    `CHK(fecActive, 1'b1)
    `CHK(laneCtrl, 8'h00)
    `WAITC(blockStart)
    `CHK(syncHeader, jtf_pkg::HDR_DATA)
    pulseGap(1'b1, n);
    `CHK(n, 8)
    // Unscrambled lane zero would only ever show the two sample octets.
    d1 = 0;
    repeat (64) begin
      @(negedge mclk);
      if (laneOctet[0] !== 8'hC3 && laneOctet[0] !== 8'h00) d1++;
    end
    `CHK(d1 > 0, 1'b1)
    // The pin synchroniser filters a one-cycle dip, so the request is held longer.
    reqSync = 1'b1;
    repeat (4) @(negedge mclk);
    reqSync = 1'b0;
    `WAITC(phaseSyncPulse)
    @(negedge mclk);
    `CHK(phaseSyncPulse, 1'b0)
    `CHK(linkState, jtf_pkg::ST_DATA)
    $display("test block mode done");
    final_report();
  end
endmodule : tb_jesd204c_transmit_framing
`default_nettype wire
